//--- rtl/cskd_exec.sv
// execution block for compare-skip-if-less and decimal adjust
//
// Operation
// - decode compare by 0110 000, bank bit, file
// - compare file byte with working, unsigned subtract
// - byte below working discards fetched follower, nop
// - skip flushes whole follower: two, three or four cycles
// - bank bit zero access bank, one bank select
// - compare one word, one cycle, two to four on a skip
// - decode decimal adjust by fixed word 0007
// - low nibble gets six above nine, digit carry
// - high nibble adds six plus carry, carry only
// - decimal adjust gives valid packed bcd for a sum of two bcd bytes, one cycle
`timescale 1ns/1ps
`include "cskd_regs.svh"

module cskd_exec
  import cskd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] instr_word_in,
  input wire logic instr_valid_in,
  input wire logic [1:0] follow_words_in,
  input wire logic [7:0] working_in,
  input wire logic carry_flag_in,
  input wire logic digit_carry_flag_in,
  input wire logic [5:0] bank_select_register_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [1:0] phase_out,
  output logic instr_ready_out,
  output logic [13:0] mem_addr_out,
  output logic mem_rd_out,
  output logic working_wr_out,
  output logic [7:0] working_data_out,
  output logic carry_wr_out,
  output logic carry_flag_out,
  output logic skip_taken_out,
  output logic flush_out,
  output logic nop_out
);

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------

  // compare-skip-if-less carries the bank bit and an 8-bit file field
  function automatic logic is_compare(input logic [15:0] word);
    is_compare = (word & `CSKD_CMP_MASK) == `CSKD_CMP_VALUE;
  endfunction : is_compare

  // decimal adjust has no operands, so the whole word must match
  function automatic logic is_daw(input logic [15:0] word);
    is_daw = word == `CSKD_DAW_WORD;
  endfunction : is_daw

  // full data address from the bank bit, bank select and file field
  function automatic logic [13:0] form_addr(
    input logic bank_bit,
    input logic [5:0] bank,
    input logic [7:0] file
  );
    logic [5:0] sel;
    sel = bank;
    if (!bank_bit)
    begin
      // access bank: low file addresses in bank zero, rest in the top
      if (file < `CSKD_ACCESS_SPLIT)
      begin
        sel = `CSKD_ACCESS_LOW_BANK;
      end
      else
      begin
        sel = `CSKD_ACCESS_HIGH_BANK;
      end
    end
    form_addr = {sel, file};
  endfunction : form_addr

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  cskd_phase_t phase_q;
  cskd_phase_t phase_d;
  cskd_op_t op_q;
  logic [7:0] file_byte_q;
  logic [7:0] work_q;
  logic carry_q;
  logic digit_carry_q;
  logic [1:0] nop_cnt_q;
  logic [1:0] nop_cnt_d;
  logic accept;
  logic [8:0] diff;
  logic [7:0] daw_result;
  logic daw_carry;

  // an instruction is taken only at q1 of a cycle that is not a flush
  assign accept = (phase_q == CSKD_PH_Q1) && (nop_cnt_q == `CSKD_NOP_RST) &&
    instr_valid_in;

  // borrow of the unsigned subtraction marks the byte as below working
  assign diff = {1'b0, file_byte_q} - {1'b0, work_q};

  // ------------------------------------------------------------------
  // phase sequencing
  // ------------------------------------------------------------------

  // next phase, one clock per phase
  always_comb
  begin
    case (phase_q)
      CSKD_PH_Q1: phase_d = CSKD_PH_Q2;
      CSKD_PH_Q2: phase_d = CSKD_PH_Q3;
      CSKD_PH_Q3: phase_d = CSKD_PH_Q4;
      CSKD_PH_Q4: phase_d = CSKD_PH_Q1;
      default: phase_d = CSKD_PH_Q1;
    endcase
  end

  // phase counter, free running from reset
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q <= CSKD_PH_Q1;
      phase_out <= 2'h0;
    end
    else
    begin
      phase_q <= phase_d;
      phase_out <= phase_d;
    end
  end

  // ------------------------------------------------------------------
  // decode and operand capture
  // ------------------------------------------------------------------

  // q1 decodes, the op is dropped again at the end of q4
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      op_q <= CSKD_OP_NONE;
    end
    else if (accept)
    begin
      if (is_compare(instr_word_in))
      begin
        op_q <= CSKD_OP_CMP;
      end
      else if (is_daw(instr_word_in))
      begin
        op_q <= CSKD_OP_DAW;
      end
      else
      begin
        op_q <= CSKD_OP_NONE;
      end
    end
    else if (phase_q == CSKD_PH_Q4)
    begin
      op_q <= CSKD_OP_NONE;
    end
  end

  // q2 reads the file byte and working with its flags
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      file_byte_q <= `CSKD_BYTE_RST;
      work_q <= `CSKD_BYTE_RST;
      carry_q <= 1'b0;
      digit_carry_q <= 1'b0;
    end
    else if (phase_q == CSKD_PH_Q2)
    begin
      file_byte_q <= mem_rdata_in;
      work_q <= working_in;
      carry_q <= carry_flag_in;
      digit_carry_q <= digit_carry_flag_in;
    end
  end

  // ------------------------------------------------------------------
  // data memory read
  // ------------------------------------------------------------------

  // read strobe stands through q2 only for a compare
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_rd_out <= 1'b0;
      mem_addr_out <= {`CSKD_ADDR_W{1'b0}};
    end
    else if (accept && is_compare(instr_word_in))
    begin
      mem_rd_out <= 1'b1;
      mem_addr_out <= form_addr(instr_word_in[`CSKD_BANK_BIT],
        bank_select_register_in, instr_word_in[7:0]);
    end
    else
    begin
      mem_rd_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // process: compare result and decimal correction
  // ------------------------------------------------------------------
  cskd_daw_unit u_daw (
    .value_in(work_q),
    .carry_flag_in(carry_q),
    .digit_carry_flag_in(digit_carry_q),
    .result_out(daw_result),
    .carry_flag_out(daw_carry)
  );

  // ------------------------------------------------------------------
  // write back in q4
  // ------------------------------------------------------------------

  // only decimal adjust writes; a compare leaves working and flags alone
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      working_wr_out <= 1'b0;
      carry_wr_out <= 1'b0;
      working_data_out <= `CSKD_BYTE_RST;
      carry_flag_out <= 1'b0;
    end
    else if (phase_q == CSKD_PH_Q3 && op_q == CSKD_OP_DAW)
    begin
      working_wr_out <= 1'b1;
      carry_wr_out <= 1'b1;
      working_data_out <= daw_result;
      carry_flag_out <= daw_carry;
    end
    else
    begin
      // compare ends in a plain no-operation phase
      working_wr_out <= 1'b0;
      carry_wr_out <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // skip and flush of the fetched follower
  // ------------------------------------------------------------------

  // flush pulses in q4 of a compare that found the byte below working
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flush_out <= 1'b0;
      skip_taken_out <= 1'b0;
    end
    else if (phase_q == CSKD_PH_Q3)
    begin
      flush_out <= (op_q == CSKD_OP_CMP) && diff[8];
      skip_taken_out <= (op_q == CSKD_OP_CMP) && diff[8];
    end
    else
    begin
      flush_out <= 1'b0;
      if (accept)
      begin
        skip_taken_out <= 1'b0;
      end
    end
  end

  // one no-operation cycle per word of the discarded follower, so the
  // compare totals two, three or four cycles; a zero count is taken as
  // one word because the fetched follower is always at least one word
  always_comb
  begin
    nop_cnt_d = nop_cnt_q;
    if (phase_q == CSKD_PH_Q4)
    begin
      if (flush_out)
      begin
        if (follow_words_in == `CSKD_NOP_RST)
        begin
          nop_cnt_d = `CSKD_MIN_FOLLOW;
        end
        else
        begin
          nop_cnt_d = follow_words_in;
        end
      end
      else if (nop_cnt_q != `CSKD_NOP_RST)
      begin
        nop_cnt_d = nop_cnt_q - `CSKD_MIN_FOLLOW;
      end
    end
  end

  // flush counter and the no-operation marker that follows it
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nop_cnt_q <= `CSKD_NOP_RST;
      nop_out <= 1'b0;
    end
    else
    begin
      nop_cnt_q <= nop_cnt_d;
      nop_out <= nop_cnt_d != `CSKD_NOP_RST;
    end
  end

  // ------------------------------------------------------------------
  // instruction handshake
  // ------------------------------------------------------------------

  // ready stands during q1 of every cycle that may take an instruction;
  // flush cycles hold it low so the discarded words never execute
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      instr_ready_out <= 1'b1;
    end
    else
    begin
      instr_ready_out <= (phase_d == CSKD_PH_Q1) &&
        (nop_cnt_d == `CSKD_NOP_RST);
    end
  end

endmodule : cskd_exec

//--- rtl/cskd_regs.svh
// constants for the compare-skip and decimal-adjust execution block
`ifndef CSKD_REGS_SVH
`define CSKD_REGS_SVH

// ------------------------------------------------------------------
// opcode decoding
// ------------------------------------------------------------------
`define CSKD_CMP_MASK 16'hfe00
`define CSKD_CMP_VALUE 16'h6000
`define CSKD_DAW_WORD 16'h0007
`define CSKD_BANK_BIT 8

// ------------------------------------------------------------------
// data memory addressing
// ------------------------------------------------------------------
`define CSKD_BANK_W 6
`define CSKD_ADDR_W 14
`define CSKD_ACCESS_SPLIT 8'h60
`define CSKD_ACCESS_LOW_BANK 6'h00
`define CSKD_ACCESS_HIGH_BANK 6'h3f

// ------------------------------------------------------------------
// decimal correction
// ------------------------------------------------------------------
`define CSKD_NIBBLE_MAX 5'h09
`define CSKD_NIBBLE_ADJ 5'h06

// ------------------------------------------------------------------
// reset values and timing counts
// ------------------------------------------------------------------
`define CSKD_BYTE_RST 8'h00
`define CSKD_WORD_RST 16'h0000
`define CSKD_NOP_RST 2'h0
`define CSKD_MIN_FOLLOW 2'h1

`endif

//--- rtl/cskd_pkg.sv
// types shared by the compare-skip and decimal-adjust execution block
package cskd_pkg;

  // four internal phases of one instruction cycle
  typedef enum logic [1:0] {
    CSKD_PH_Q1,
    CSKD_PH_Q2,
    CSKD_PH_Q3,
    CSKD_PH_Q4
  } cskd_phase_t;

  // operation held for the instruction in flight
  typedef enum logic [1:0] {
    CSKD_OP_NONE,
    CSKD_OP_CMP,
    CSKD_OP_DAW
  } cskd_op_t;

endpackage : cskd_pkg

//--- rtl/cskd_daw_unit.sv
// packed bcd correction arithmetic for the working register
`timescale 1ns/1ps
`include "cskd_regs.svh"

module cskd_daw_unit
  import cskd_pkg::*;
(
  input wire logic [7:0] value_in,
  input wire logic carry_flag_in,
  input wire logic digit_carry_flag_in,
  output logic [7:0] result_out,
  output logic carry_flag_out
);

  logic [4:0] low_sum;
  logic [4:0] high_sum;
  logic low_fix;
  logic high_fix;
  logic low_carry;

  // ------------------------------------------------------------------
  // low nibble: add six past nine or after a digit carry
  // ------------------------------------------------------------------
  always_comb
  begin
    low_fix = ({1'b0, value_in[3:0]} > `CSKD_NIBBLE_MAX) ||
      digit_carry_flag_in;
    if (low_fix)
    begin
      low_sum = {1'b0, value_in[3:0]} + `CSKD_NIBBLE_ADJ;
    end
    else
    begin
      low_sum = {1'b0, value_in[3:0]};
    end
    // the decimal carry out of the low digit feeds the high digit, so
    // that a result like ce becomes 34 and stays valid bcd
    low_carry = low_sum[4];
  end

  // ------------------------------------------------------------------
  // high nibble: add the low digit carry, then six past nine or after a carry, carry is the only flag
  // ------------------------------------------------------------------
  always_comb
  begin
    high_sum = {1'b0, value_in[7:4]} + {4'h0, low_carry};
    high_fix = (high_sum > `CSKD_NIBBLE_MAX) || carry_flag_in;
    if (high_fix)
    begin
      high_sum = high_sum + `CSKD_NIBBLE_ADJ;
    end
    result_out = {high_sum[3:0], low_sum[3:0]};
    carry_flag_out = carry_flag_in | high_sum[4];
  end

endmodule : cskd_daw_unit

//--- testbench/cskd_exec_properties.sv
// concurrent checks on the ports of the execution block
`timescale 1ns/1ps

module cskd_exec_properties
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] instr_word_in,
  input wire logic instr_valid_in,
  input wire logic [1:0] follow_words_in,
  input wire logic [7:0] working_in,
  input wire logic carry_flag_in,
  input wire logic digit_carry_flag_in,
  input wire logic [5:0] bank_select_register_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [1:0] phase_out,
  input wire logic instr_ready_out,
  input wire logic [13:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic working_wr_out,
  input wire logic [7:0] working_data_out,
  input wire logic carry_wr_out,
  input wire logic carry_flag_out,
  input wire logic skip_taken_out,
  input wire logic flush_out,
  input wire logic nop_out
);
  // ------------------------------------------------------------------
  // sequences and properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // an instruction accepted at the end of q1
  sequence take_any;
    phase_out == 2'h0 && instr_ready_out && instr_valid_in;
  endsequence
  sequence cmp_take;
    take_any ##0 (instr_word_in & 16'hfe00) == 16'h6000;
  endsequence
  sequence daw_take;
    take_any ##0 instr_word_in == 16'h0007;
  endsequence
  // a flushed follower word costs four idle phases
  sequence nop_run;
    (nop_out && !instr_ready_out) [*4];
  endsequence

  rd_after_cmp_a: assert property (cmp_take |=> mem_rd_out && phase_out == 2'h1)
    else $error("compare did not read in q2");
  cmp_addr_a: assert property (cmp_take ##0 instr_word_in[8] |=>
    mem_addr_out == {$past(bank_select_register_in), $past(instr_word_in[7:0])})
    else $error("banked compare address wrong");
  flush_cause_a: assert property (mem_rd_out |-> ##2
    flush_out == ($past(mem_rdata_in, 2) < $past(working_in, 2)))
    else $error("flush does not follow unsigned compare");
  skip_nop_a: assert property (flush_out |=> nop_run)
    else $error("skip did not run no-operation phases");
  cmp_quiet_a: assert property (cmp_take |=>
    (!working_wr_out && !carry_wr_out) [*4])
    else $error("compare wrote back");
  daw_write_a: assert property (daw_take |-> ##3 working_wr_out && carry_wr_out)
    else $error("decimal adjust write missing");
  wr_pulse_a: assert property (working_wr_out |->
    carry_wr_out && phase_out == 2'h3 ##1 !working_wr_out)
    else $error("working write not a q4 pulse");
  rd_pulse_a: assert property (mem_rd_out |=> !mem_rd_out)
    else $error("read strobe longer than one clock");
endmodule : cskd_exec_properties

bind cskd_exec cskd_exec_properties u_cskd_exec_properties (.clk_in, .rst_in,
  .instr_word_in, .instr_valid_in, .follow_words_in, .working_in,
  .carry_flag_in, .digit_carry_flag_in, .bank_select_register_in,
  .mem_rdata_in, .phase_out, .instr_ready_out, .mem_addr_out, .mem_rd_out,
  .working_wr_out, .working_data_out, .carry_wr_out, .carry_flag_out,
  .skip_taken_out, .flush_out, .nop_out);

//--- testbench/cskd_exec_tb.sv
// self-checking bench for the compare-skip and decimal-adjust block
`timescale 1ns/1ps

module cskd_exec_tb;
  import cskd_pkg::*;
  logic clk_in, rst_in, instr_valid_in, carry_flag_in, digit_carry_flag_in;
  logic [15:0] instr_word_in;
  logic [1:0] follow_words_in, phase_out;
  logic [7:0] working_in, mem_rdata_in, working_data_out;
  logic [5:0] bank_select_register_in;
  logic [13:0] mem_addr_out;
  logic instr_ready_out, mem_rd_out, working_wr_out, carry_wr_out;
  logic carry_flag_out, skip_taken_out, flush_out, nop_out;
  int n_errors, cmp_count;

  cskd_exec u_cskd_exec (.clk_in, .rst_in, .instr_word_in, .instr_valid_in,
    .follow_words_in, .working_in, .carry_flag_in, .digit_carry_flag_in,
    .bank_select_register_in, .mem_rdata_in, .phase_out, .instr_ready_out,
    .mem_addr_out, .mem_rd_out, .working_wr_out, .working_data_out,
    .carry_wr_out, .carry_flag_out, .skip_taken_out, .flush_out, .nop_out);

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // waits for a free q1, offers one word, returns at the q2 falling edge
  task automatic issue(input logic [15:0] w, input logic [5:0] b);
    int k;
    k = 0;
    while (!(phase_out === 2'h0 && instr_ready_out === 1'b1) && k < 100)
    begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 100)
      n_errors++; // no free q1 came: the design hung in a flush
    instr_word_in = w;
    bank_select_register_in = b;
    instr_valid_in = 1'b1;
    @(negedge clk_in);
    instr_valid_in = 1'b0;
    bank_select_register_in = ~b;
  endtask : issue

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic do_cmp(input logic a, input logic [7:0] f,
    input logic [5:0] b, input logic [7:0] byt, input logic [7:0] w,
    input logic [1:0] n, input logic [13:0] ea);
    logic skip;
    int cnt;
    skip = byt < w;
    issue({7'h30, a, f}, b);
    mem_rdata_in = byt;
    working_in = w;
    follow_words_in = n;
    chk(16'(mem_rd_out), 16'h0001);
    chk(16'(mem_addr_out), 16'(ea));
    @(negedge clk_in);
    mem_rdata_in = ~byt; // stale byte must not be reused
    @(negedge clk_in);
    chk(16'(flush_out), 16'(skip));
    chk(16'(working_wr_out | carry_wr_out), 16'h0000);
    @(negedge clk_in);
    chk(16'(skip_taken_out), 16'(skip));
    cnt = 0;
    while (nop_out === 1'b1 && cnt < 20)
    begin
      @(negedge clk_in);
      cnt++;
    end
    chk(16'(cnt), skip ? 16'(4 * n) : 16'h0000);
    chk(16'(instr_ready_out), 16'h0001);
  endtask : do_cmp

  task automatic do_daw(input logic [7:0] w, input logic c, input logic dc);
    logic [8:0] v;
    v = {1'b0, w};
    if (w[3:0] > 4'h9 || dc)
      v = v + 9'h006;
    if (v[8:4] > 5'h09 || c)
      v = v + 9'h060;
    issue(16'h0007, 6'h00);
    working_in = w;
    carry_flag_in = c;
    digit_carry_flag_in = dc;
    repeat (2) @(negedge clk_in);
    chk(16'(working_wr_out & carry_wr_out), 16'h0001);
    chk(16'(working_data_out), 16'(v[7:0]));
    chk(16'(carry_flag_out), 16'(c | v[8]));
    @(negedge clk_in);
    chk(16'(working_wr_out), 16'h0000);
  endtask : do_daw

  // a near-miss opcode must be consumed silently
  task automatic do_other();
    issue(16'h6200, 6'h01);
    chk(16'(mem_rd_out), 16'h0000);
    repeat (3) @(negedge clk_in);
    chk({13'h0000, phase_out, instr_ready_out}, 16'h0001);
  endtask : do_other

  // ------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // whole run is well under a thousand clocks
  initial
  begin
    #50000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    rst_in = 1'b1;
    instr_valid_in = 1'b0;
    instr_word_in = 16'h0000;
    follow_words_in = 2'h1;
    working_in = 8'h00;
    carry_flag_in = 1'b0;
    digit_carry_flag_in = 1'b0;
    bank_select_register_in = 6'h00;
    mem_rdata_in = 8'h00;
    n_errors = 0;
    cmp_count = 0;
    repeat (20) @(negedge clk_in);
    chk({11'h000, phase_out, instr_ready_out, mem_rd_out, nop_out},
      16'h0004);
    rst_in = 1'b0;
    do_cmp(1'b0, 8'h10, 6'h05, 8'h40, 8'h40, 2'h1, 14'h0010);
    do_cmp(1'b1, 8'h22, 6'h2a, 8'h7f, 8'h80, 2'h1, 14'h2a22);
    do_cmp(1'b0, 8'h60, 6'h05, 8'h03, 8'hf0, 2'h2, 14'h3f60);
    do_cmp(1'b0, 8'h5f, 6'h05, 8'h00, 8'h01, 2'h3, 14'h005f);
    do_cmp(1'b1, 8'hff, 6'h3f, 8'hff, 8'h00, 2'h1, 14'h3fff);
    do_daw(8'ha5, 1'b0, 1'b0);
    do_daw(8'hce, 1'b0, 1'b0);
    do_daw(8'h09, 1'b0, 1'b1);
    do_daw(8'h12, 1'b1, 1'b0);
    do_daw(8'h99, 1'b0, 1'b0);
    do_daw(8'hff, 1'b0, 1'b0);
    do_other();
    wrap_up();
  end
endmodule : cskd_exec_tb
